// >>> core/mgmt_serial_read_addr_counter.sv
`timescale 1ns/100ps
module mgmt_serial_read_addr_counter (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic LINK_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic MODULE_SELECT_N,
  input wire logic MEM_WE,
  input wire logic [7:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic SDA_OUT,
  output logic SDA_OE
);

  // ==========================================================
  // System domain: backing store and fetch responder
  // ==========================================================
  logic [7:0] mem [0:mgmt_serial_pkg::MEM_DEPTH-1]; // Byte store
  logic req_s1; // First stage of the fetch request toggle
  logic req_s2; // Second stage, safe to read
  logic req_seen; // Last request toggle served
  logic [7:0] sys_data; // Byte handed to the link
  logic ack_tgl; // Answer toggle back to the link
  logic next_req_seen;
  logic [7:0] next_sys_data;
  logic next_ack_tgl;
  logic [7:0] addr_cnt; // Byte-address counter (link domain)
  logic req_tgl; // Fetch request toggle (link domain)

  // Store is filled by the user side; no reset on purpose
  always_ff @(posedge CLK_SYS) begin
    if (MEM_WE) begin
      mem[MEM_ADDR] <= MEM_WDATA;
    end
  end

  // Serve a fetch when the request toggle moves; the counter is
  // stable for many cycles after each toggle, so it is read here
  always_comb begin
    next_req_seen = req_seen;
    next_sys_data = sys_data;
    next_ack_tgl = ack_tgl;
    if (req_s2 != req_seen) begin
      next_req_seen = req_s2;
      next_sys_data = mem[addr_cnt];
      next_ack_tgl = ~ack_tgl;
    end
  end

  // Registers of the system side
  always_ff @(posedge CLK_SYS) begin
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
    if (RESET) begin
      req_seen <= 1'h0;
      sys_data <= 8'h00;
      ack_tgl <= 1'h0;
    end else begin
      req_seen <= next_req_seen;
      sys_data <= next_sys_data;
      ack_tgl <= next_ack_tgl;
    end
  end

  // ==========================================================
  // Link domain: synchronisers
  // ==========================================================
  logic rst_s1, link_rst; // Reset brought into the link domain
  logic scl_s1, scl; // Clock pin synchroniser
  logic sda_s1, sda; // Data pin synchroniser
  logic sel_s1, sel_n; // Module select synchroniser
  logic ack_s1, ack_s2; // Answer toggle synchroniser
  logic scl_d, sda_d; // Previous synchronised levels

  // Two flops per incoming level; only the second is used
  always_ff @(posedge LINK_CLK) begin
    rst_s1 <= RESET;
    link_rst <= rst_s1;
    scl_s1 <= SCL_IN;
    scl <= scl_s1;
    sda_s1 <= SDA_IN;
    sda <= sda_s1;
    sel_s1 <= MODULE_SELECT_N;
    sel_n <= sel_s1;
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
    scl_d <= scl;
    sda_d <= sda;
  end

  // ==========================================================
  // Link domain: protocol engine
  // ==========================================================
  // Bus conditions seen from the sampled pins
  logic start_ev, stop_ev, scl_rise, scl_fall;
  assign start_ev = scl & scl_d & sda_d & ~sda;
  assign stop_ev = scl & scl_d & ~sda_d & sda;
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;

  mgmt_serial_pkg::link_state_e state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt; // Bits seen in this byte
  logic [7:0] shreg, next_shreg; // Received byte, MSB first
  logic [7:0] tx_byte, next_tx_byte; // Byte being sent
  logic [7:0] rd_byte, next_rd_byte; // Prefetched byte at counter
  logic [7:0] next_addr_cnt;
  logic next_req_tgl;
  logic ack_seen, next_ack_seen; // Last answer toggle taken
  logic host_nack, next_host_nack; // Host left the ack high
  logic oe, next_oe; // Pull the data line low

  // Counter step that stays inside the current page
  function automatic logic [7:0] page_inc(input logic [7:0] a);
    page_inc = {a[mgmt_serial_pkg::PAGE_BIT],
                a[6:0] + 7'h01};
  endfunction

  // Next state of the whole link engine
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx_byte = tx_byte;
    next_rd_byte = rd_byte;
    next_addr_cnt = addr_cnt;
    next_req_tgl = req_tgl;
    next_ack_seen = ack_seen;
    next_host_nack = host_nack;
    next_oe = oe;
    // Take a fetched byte when the answer arrives
    if (ack_s2 != ack_seen) begin
      next_ack_seen = ack_s2;
      next_rd_byte = sys_data;
    end
    // Received bits are captured on the rising clock
    if (scl_rise) begin
      next_shreg = {shreg[6:0], sda};
      next_bit_cnt = bit_cnt + 4'h1;
      next_host_nack = sda;
    end
    if (stop_ev) begin
      // STOP ends anything; the counter is kept as it is
      next_state = mgmt_serial_pkg::ST_IDLE;
      next_oe = 1'h0;
    end else if (start_ev) begin
      // START or repeated START restarts address recognition
      next_oe = 1'h0;
      next_bit_cnt = 4'h0;
      if (sel_n) begin
        next_state = mgmt_serial_pkg::ST_IDLE;
      end else begin
        next_state = mgmt_serial_pkg::ST_DEV;
      end
    end else if (scl_fall) begin
      unique case (state)
        mgmt_serial_pkg::ST_IDLE: begin
          next_oe = 1'h0;
        end
        mgmt_serial_pkg::ST_DEV: begin
          // Full address byte in: ack only on a match
          if (bit_cnt == mgmt_serial_pkg::BYTE_BITS) begin
            if (shreg[7:1] == mgmt_serial_pkg::DEV_ADDR &&
                !sel_n) begin
              next_oe = 1'h1;
              next_state = mgmt_serial_pkg::ST_DEV_ACK;
            end else begin
              next_state = mgmt_serial_pkg::ST_IDLE;
            end
          end
        end
        mgmt_serial_pkg::ST_DEV_ACK: begin
          next_bit_cnt = 4'h0;
          // The ack bit shifted in at the ninth rise, so the
          // direction bit now sits one place up
          if (shreg[1] == mgmt_serial_pkg::DIR_READ) begin
            // Read: first bit of the byte at the counter
            next_tx_byte = rd_byte;
            next_oe = ~rd_byte[7];
            next_state = mgmt_serial_pkg::ST_RDATA;
          end else begin
            next_oe = 1'h0;
            next_state = mgmt_serial_pkg::ST_WADDR;
          end
        end
        mgmt_serial_pkg::ST_WADDR: begin
          if (bit_cnt == mgmt_serial_pkg::BYTE_BITS) begin
            // Load the counter and fetch the byte it names
            next_addr_cnt = shreg;
            next_req_tgl = ~req_tgl;
            next_oe = 1'h1;
            next_state = mgmt_serial_pkg::ST_WADDR_ACK;
          end
        end
        mgmt_serial_pkg::ST_WADDR_ACK,
        mgmt_serial_pkg::ST_WDATA_ACK: begin
          next_oe = 1'h0;
          next_bit_cnt = 4'h0;
          next_state = mgmt_serial_pkg::ST_WDATA;
        end
        mgmt_serial_pkg::ST_WDATA: begin
          if (bit_cnt == mgmt_serial_pkg::BYTE_BITS) begin
            // Byte taken: ack it and step the counter
            next_addr_cnt = page_inc(addr_cnt);
            next_req_tgl = ~req_tgl;
            next_oe = 1'h1;
            next_state = mgmt_serial_pkg::ST_WDATA_ACK;
          end
        end
        mgmt_serial_pkg::ST_RDATA: begin
          if (bit_cnt == mgmt_serial_pkg::BYTE_BITS) begin
            // Byte sent: release for the host ack, step counter
            next_oe = 1'h0;
            next_addr_cnt = page_inc(addr_cnt);
            next_req_tgl = ~req_tgl;
            next_state = mgmt_serial_pkg::ST_RACK;
          end else begin
            next_oe = ~tx_byte[3'(4'h7 - bit_cnt)];
          end
        end
        mgmt_serial_pkg::ST_RACK: begin
          next_bit_cnt = 4'h0;
          if (host_nack) begin
            // No ack: stay off the line until the next START
            next_oe = 1'h0;
            next_state = mgmt_serial_pkg::ST_IDLE;
          end else begin
            // Acked: send the byte at the new counter value
            next_tx_byte = rd_byte;
            next_oe = ~rd_byte[7];
            next_state = mgmt_serial_pkg::ST_RDATA;
          end
        end
      endcase
    end
  end

  // Link registers; counter keeps its value across frames
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      state <= mgmt_serial_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx_byte <= 8'h00;
      rd_byte <= 8'h00;
      addr_cnt <= mgmt_serial_pkg::ADDR_RESET;
      req_tgl <= 1'h1; // Prefetch address zero after reset
      ack_seen <= 1'h0;
      host_nack <= 1'h1;
      oe <= 1'h0;
      SDA_OE <= 1'h0;
      SDA_OUT <= 1'h0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx_byte <= next_tx_byte;
      rd_byte <= next_rd_byte;
      addr_cnt <= next_addr_cnt;
      req_tgl <= next_req_tgl;
      ack_seen <= next_ack_seen;
      host_nack <= next_host_nack;
      oe <= next_oe;
      SDA_OE <= next_oe; // Open drain: enable means pull low
      SDA_OUT <= 1'h0;
    end
  end

endmodule

// >>> core/mgmt_serial_pkg.sv
package mgmt_serial_pkg;

  // Seven address bits that select this device on the two-wire link
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // Direction bit values in the eighth address bit
  localparam logic DIR_READ = 1'h1;
  // Bits in one byte on the link
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Width of the byte-address counter and of stored data
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Bytes of backing store reached through the counter
  localparam int MEM_DEPTH = 256;
  // Counter value after reset
  localparam logic [7:0] ADDR_RESET = 8'h00;
  // Top counter bit picks the 128-byte page and is kept on wrap
  localparam int PAGE_BIT = 7;

  // Link protocol states
  typedef enum logic [3:0] {
    ST_IDLE,       // Waiting for a START
    ST_DEV,        // Shifting in the device address byte
    ST_DEV_ACK,    // Driving the acknowledge of the address byte
    ST_WADDR,      // Shifting in the byte address
    ST_WADDR_ACK,  // Acknowledging the byte address
    ST_WDATA,      // Shifting in a written data byte
    ST_WDATA_ACK,  // Acknowledging a written data byte
    ST_RDATA,      // Shifting out a read data byte
    ST_RACK        // Sampling the host acknowledge of a read byte
  } link_state_e;

endpackage

// >>> test/mgmt_serial_props.sv
`timescale 1ns/100ps
// ==========
// Link-side checks on the data drive
module mgmt_serial_props (
  input wire logic LINK_CLK,
  input wire logic RESET,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic MODULE_SELECT_N,
  input wire logic SDA_OUT,
  input wire logic SDA_OE
);
  // Link logic leaves reset two link edges after RESET falls, so
  // checks stay off until that tail has passed
  logic [2:0] rst_hold = 3'h7;
  default clocking cb @(posedge LINK_CLK); endclocking
  default disable iff (RESET || rst_hold != 3'h0);
  always @(posedge LINK_CLK) rst_hold <= {rst_hold[1:0], RESET};
  // Drive stays off for a while
  sequence quiet8;
    !SDA_OE[*8];
  endsequence
  // Bus conditions, clock high
  sequence stop_seen;
    SCL_IN && $rose(SDA_IN);
  endsequence
  sequence start_seen;
    SCL_IN && $fell(SDA_IN);
  endsequence
  out_zero_a: assert property (SDA_OUT == 1'h0)
    else $error("data value not low");
  oe_timing_a: assert property (
    $changed(SDA_OE) && !SCL_IN |->
    $past(SCL_IN, 6) && !$past(SCL_IN, 2))
    else $error("drive change not after clock fall");
  oe_stands_a: assert property (
    $changed(SDA_OE) && !SCL_IN |=> $stable(SDA_OE)[*8])
    else $error("drive did not stand");
  ack_hold_a: assert property ($rose(SDA_OE) |-> SDA_OE[*8])
    else $error("pull too short");
  stop_quiet_a: assert property (stop_seen |-> ##4 quiet8)
    else $error("drive after stop");
  start_quiet_a: assert property (start_seen |-> ##4 quiet8)
    else $error("drive after start");
  select_gate_a: assert property (
    $rose(SDA_OE) |-> !$past(MODULE_SELECT_N, 8))
    else $error("drive while deselected");
  rel_low_a: assert property ($fell(SDA_OE) |-> !SCL_IN)
    else $error("release with clock high");
endmodule
bind mgmt_serial_read_addr_counter mgmt_serial_props u_props (.*);

// >>> test/mgmt_host_model.sv
`timescale 1ns/100ps
// ==========
// Two-wire bus master model
module mgmt_host_model (
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic sda_h = 1'h1; // Host side, high = released
  initial scl = 1'h1; // Clock rests high outside frames
  // Pulled-up wire, low if anyone pulls
  assign sda = (sda_oe ? sda_out : 1'h1) & sda_h;
  // One clock phase; long enough for the counter crossing
  task automatic w;
    repeat (150) @(posedge clk);
    #1;
  endtask
  // One bit; data moves only with clock low
  task automatic xbit(input logic b, output logic r);
    sda_h = b;
    w();
    scl = 1'h1;
    w();
    r = sda;
    scl = 1'h0;
  endtask
  task automatic start;
    sda_h = 1'h1;
    w();
    scl = 1'h1;
    w();
    sda_h = 1'h0;
    w();
    scl = 1'h0;
  endtask
  task automatic stop;
    sda_h = 1'h0;
    w();
    scl = 1'h1;
    w();
    sda_h = 1'h1;
    w();
  endtask
  // Byte out MSB first; ack low when taken
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'h1, ack);
  endtask
  // Byte in; last leaves ack released
  task automatic rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'h1, d[i]);
    xbit(last, r);
  endtask
endmodule

// >>> test/mgmt_serial_read_addr_counter_tb_top.sv
`timescale 1ns/100ps
// ==========
// Bench for the read path and address counter
module mgmt_serial_read_addr_counter_tb_top;
  logic clk = 1'h0;
  logic lclk = 1'h0;
  logic rst = 1'h1;
  logic sel_n = 1'h0;
  logic mem_we = 1'h0;
  logic [7:0] mem_addr = 8'h00;
  logic [7:0] mem_wdata = 8'h00;
  logic scl, sda, sda_out, sda_oe, ack;
  logic [7:0] d;
  logic [7:0] la [6] = '{8'h7e, 8'h7f, 8'h00, 8'h80, 8'h81, 8'h82};
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #2 clk = ~clk;
  // Odd start keeps link clock out of phase
  initial begin
    #7.3;
    forever #15 lclk = ~lclk;
  end
  mgmt_serial_read_addr_counter DUT (.CLK_SYS(clk), .RESET(rst),
    .LINK_CLK(lclk), .SCL_IN(scl), .SDA_IN(sda), .MODULE_SELECT_N(sel_n),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe));
  mgmt_host_model host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out),
    .scl(scl), .sda(sda));
  // ==========
  // Store content is a fixed function of address
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic mw(input logic [7:0] a);
    @(posedge clk);
    #1;
    mem_we = 1'h1;
    mem_addr = a;
    mem_wdata = pat(a);
    @(posedge clk);
    #1;
    mem_we = 1'h0;
  endtask
  // Address byte with expected ack level
  task automatic adr(input logic [7:0] a, input logic [7:0] e);
    host.wb(a, ack);
    chk({7'h0, ack}, e);
  endtask
  task automatic cur_read(input logic [7:0] e);
    host.start();
    adr(8'ha1, 8'h00);
    host.rb(1'h1, d);
    chk(d, e);
    host.stop();
  endtask
  // Dummy write to page end, read across the wrap
  task automatic t_random;
    host.start();
    adr(8'ha0, 8'h00);
    adr(8'h7e, 8'h00);
    host.start();
    adr(8'ha1, 8'h00);
    host.rb(1'h0, d);
    chk(d, pat(8'h7e));
    host.rb(1'h1, d);
    chk(d, pat(8'h7f));
    host.stop();
    cur_read(pat(8'h00));
    $display("t_random done");
  endtask
  // Written bytes count; wrap stays in upper page
  task automatic t_write;
    host.start();
    adr(8'ha0, 8'h00);
    adr(8'hff, 8'h00);
    adr(8'h3c, 8'h00);
    host.stop();
    cur_read(pat(8'h80));
    $display("t_write done");
  endtask
  // Deselected, then wrong address: no ack
  task automatic t_refuse;
    sel_n = 1'h1;
    host.start();
    adr(8'ha1, 8'h01);
    host.stop();
    sel_n = 1'h0;
    host.start();
    adr(8'ha3, 8'h01);
    host.stop();
    $display("t_refuse done");
  endtask
  // Stop mid-byte leaves the counter alone
  task automatic t_abort;
    host.start();
    adr(8'ha0, 8'h00);
    for (int i = 0; i < 3; i++) host.xbit(1'h0, ack);
    host.stop();
    cur_read(pat(8'h81));
    $display("t_abort done");
  endtask
  // START mid-byte restarts address recognition, counter kept
  task automatic t_restart;
    host.start();
    adr(8'ha0, 8'h00);
    for (int i = 0; i < 3; i++) host.xbit(1'h1, ack);
    host.start();
    adr(8'ha1, 8'h00);
    host.rb(1'h1, d);
    chk(d, pat(8'h82));
    host.stop();
    $display("t_restart done");
  endtask
  task automatic summarize;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'h0;
    for (int i = 0; i < 6; i++) mw(la[i]);
    repeat (200) @(posedge clk);
    t_random();
    t_write();
    t_refuse();
    t_abort();
    t_restart();
    summarize();
  end
  // Hang guard, above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      summarize();
    end
  end
endmodule
